// *** inc/fwg_pkg.sv ***
// constants, opcodes and types for the flash write guard
`default_nettype none
package fwg_pkg;
  // apb byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00; // opcode of the current selection
  localparam logic [7:0] OFS_ADDR   = 8'h04; // 24-bit command address
  localparam logic [7:0] OFS_SRDATA = 8'h08; // data for a status write
  localparam logic [7:0] OFS_STATUS = 8'h0c; // live state, read only
  localparam logic [7:0] OFS_PROT   = 8'h10; // protection bits, read only
  // instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD    = 8'h06; // write_enable_cmd
  localparam logic [7:0] OP_WRDIS   = 8'h04; // write_disable_cmd
  localparam logic [7:0] OP_SRW     = 8'h01; // status_write_cmd
  localparam logic [7:0] OP_SRW2    = 8'h31; // status2_write_cmd
  localparam logic [7:0] OP_SRW3    = 8'h11; // status3_write_cmd
  localparam logic [7:0] OP_PAGE    = 8'h02; // page_program_cmd
  localparam logic [7:0] OP_QPAGE   = 8'h32; // quad_page_program_cmd
  localparam logic [7:0] OP_SEC     = 8'h20; // four_k_wipe_cmd
  localparam logic [7:0] OP_HALF    = 8'h52; // half_block_erase_cmd
  localparam logic [7:0] OP_BLOCK   = 8'hd8; // full_block_wipe_cmd
  localparam logic [7:0] OP_CHIP    = 8'hc7; // whole-array erase
  localparam logic [7:0] OP_SLEEP   = 8'hb9; // deep_sleep_enter_cmd
  localparam logic [7:0] OP_WAKE    = 8'hab; // wake_and_id_cmd
  // array geometry
  localparam logic [23:0] ARRAY_TOP = 24'h1fffff; // last byte of the array
  localparam logic [23:0] BLK_SIZE  = 24'h010000; // 64KB block
  localparam logic [23:0] SEC_SIZE  = 24'h001000; // 4KB sector
  localparam logic [23:0] PAGE_MSK  = 24'h0000ff; // page offset bits
  localparam logic [23:0] SEC_MSK   = 24'h000fff; // sector offset bits
  localparam logic [23:0] HALF_MSK  = 24'h007fff; // half block offset bits
  localparam logic [23:0] BLK_MSK   = 24'h00ffff; // block offset bits
  localparam logic [2:0]  GRAN_CAP  = 3'h3;       // largest 4KB shift (32KB)
  // reset values
  localparam logic [7:0]  PROT_RST  = 8'h00;
  localparam logic [7:0]  OPC_RST   = 8'h00;
  // timing
  localparam int CLK_MHZ = 100;       // pclk rate
  localparam int PUW_NS  = 1000000;   // power_up_write_inhibit_time in ns
  localparam int PUW_CYC = (PUW_NS * CLK_MHZ + 999) / 1000; // rounded up
  // protection bits as held in the status register
  typedef struct packed {
    logic       status_protect_bit1; // status_protect_bit1
    logic       srp0; // status_protect_bit0
    logic       cmp;  // complement_select
    logic       gran; // granularity_select
    logic       tb;   // top_bottom_select
    logic [2:0] bp;   // block_protect_bit2..0
  } fwg_prot_s;
  // power states, one-hot
  typedef enum logic [2:0] {
    PW_INHIBIT = 3'b001,
    PW_NORMAL  = 3'b010,
    PW_DEEP    = 3'b100
  } fwg_pwr_e;
endpackage : fwg_pkg
`default_nettype wire

// *** verilog/fwg_guard.sv ***
// write guard, protected range decode and power modes of the serial flash
// Behaviour
// RL1 - busy flag set during internal cycles
// RL2 - active while selected or cycle runs
// RL3 - sleep command enters deep power-down
// RL4 - deep power-down ignores all but wake
// RL5 - modifying commands need multiple-of-eight clocks
// RL6 - modifying commands need write-enable latch set
// RL7 - latch cleared at reset and listed completions
// RL8 - power-up timer blocks modifications
// RL9 - protection bits define read-only region
// RL10 - write-protect pin locks protection bits
// RL11 - top 64KB blocks protected by code
// RL12 - bottom 64KB blocks protected by code
// RL13 - bits 2,1 set protect all; 000 none
// RL14 - top 4KB granular regions protected
// RL15 - bottom 4KB granular regions protected
// RL16 - complement bit inverts protected range
// RL17 - command touching protected region ignored
// RL18 - array access ignored during internal cycle
// RL19 - range decode combinational against full address
// RL20 - busy set when cycle starts, cleared end
//
// The APB slave port and the register addresses were decided locally.
`default_nettype none
module fwg_guard
  import fwg_pkg::*;
#(
  parameter int PUW_CYCLES = PUW_CYC // power-up inhibit, shorten in simulation
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        wp_n,
  input  wire logic        cycle_done,
  output logic             cycle_start,
  output logic      [7:0]  cycle_opcode,
  output logic             active_mode,
  output logic             deep_sleep
);
  // pin synchronisers
  logic cs_q1, cs_q2, cs_q3;       // chip select stages
  logic ck_q1, ck_q2, ck_q3;       // serial clock stages
  logic wp_q1, wp_q2;              // write protect stages
  // state
  fwg_pwr_e   pwr_r, pwr_nxt;      // power state
  logic [16:0] puw_r, puw_nxt;     // power-up inhibit counter
  logic [2:0] bits_r, bits_nxt;    // clock pulses mod eight
  logic       seen_r, seen_nxt;    // at least one pulse this selection
  logic       wip_r, wip_nxt;      // write_in_progress_flag
  logic       wel_r, wel_nxt;      // write_enable_latch
  fwg_prot_s  prot_r, prot_nxt;    // protection bits
  logic       rej_r, rej_nxt;      // last finished selection refused
  logic       start_r, start_nxt;  // one-cycle cycle start pulse
  logic [7:0] kind_r, kind_nxt;    // opcode of the running cycle
  logic [7:0] opc_r, opc_nxt;      // software opcode register
  logic [23:0] addr_r, addr_nxt;   // software address register
  logic [7:0] srd_r, srd_nxt;      // software status data register
  logic [31:0] rd_r, rd_nxt;       // apb read data
  logic       err_r, err_nxt;      // apb error for unmapped
  // decode terms
  logic       cs_fall, cs_rise, ck_rise;
  logic       is_mod, is_array, hardware_protected_mode, hit, go;
  logic [23:0] psize, plo, phi, tlo, thi;
  logic       pnone, pall;

  // three flops on chip select and serial clock, two on write protect, first stage read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q1 <= 1'b1;
      cs_q2 <= 1'b1;
      cs_q3 <= 1'b1;
      ck_q1 <= 1'b0;
      ck_q2 <= 1'b0;
      ck_q3 <= 1'b0;
      wp_q1 <= 1'b1;
      wp_q2 <= 1'b1;
    end else begin
      cs_q1 <= cs_n;
      cs_q2 <= cs_q1;
      cs_q3 <= cs_q2;
      ck_q1 <= sclk;
      ck_q2 <= ck_q1;
      ck_q3 <= ck_q2;
      wp_q1 <= wp_n;
      wp_q2 <= wp_q1;
    end
  end

  // edges of the synchronised pins
  assign cs_fall = cs_q3 & ~cs_q2;
  assign cs_rise = cs_q2 & ~cs_q3;
  assign ck_rise = ck_q2 & ~ck_q3;
  // pin locks the protection bits when status_protect_bit0 is set
  assign hardware_protected_mode     = ~wp_q2 & prot_r.srp0; // [RL10]

  // command classes
  always_comb begin
    is_array = (opc_r == OP_PAGE) || (opc_r == OP_QPAGE) || (opc_r == OP_SEC)
            || (opc_r == OP_HALF) || (opc_r == OP_BLOCK) || (opc_r == OP_CHIP);
    is_mod   = is_array || (opc_r == OP_SRW) || (opc_r == OP_SRW2)
            || (opc_r == OP_SRW3);
  end

  // protected range from the current bits, no register in the path
  always_comb begin
    psize = '0;
    pnone = (prot_r.bp == 3'h0);                          // [RL13]
    pall  = (prot_r.bp[2:1] == 2'h3);                     // [RL13]
    if (prot_r.gran) begin
      // 4KB steps, codes 10x cap at 32KB
      if ((prot_r.bp - 3'h1) > GRAN_CAP) psize = SEC_SIZE << GRAN_CAP; // [RL14] [RL15]
      else psize = SEC_SIZE << (prot_r.bp - 3'h1);        // [RL14] [RL15]
    end else begin
      psize = BLK_SIZE << (prot_r.bp - 3'h1);             // [RL11] [RL12]
    end
    if (prot_r.tb) begin
      plo = '0;                                           // [RL12] [RL15]
      phi = psize - 24'h000001;
    end else begin
      plo = ARRAY_TOP - psize + 24'h000001;               // [RL11] [RL14]
      phi = ARRAY_TOP;
    end
    if (prot_r.cmp) begin
      // complement of a top or bottom anchored range is the other end
      if (prot_r.tb) begin
        plo = psize;                                      // [RL16]
        phi = ARRAY_TOP;
      end else begin
        phi = ARRAY_TOP - psize;                          // [RL16]
        plo = '0;
      end
      if (pall) begin
        pnone = 1'b1;                                     // [RL16]
        pall  = 1'b0;
      end else if (pnone) begin
        pnone = 1'b0;                                     // [RL16]
        pall  = 1'b1;
      end
    end
    if (pall) begin
      plo = '0;                                           // [RL13] [RL9]
      phi = ARRAY_TOP;
    end
  end

  // region touched by the command, full 24-bit address
  always_comb begin
    tlo = addr_r;
    thi = addr_r;
    if ((opc_r == OP_PAGE) || (opc_r == OP_QPAGE)) begin
      tlo = addr_r & ~PAGE_MSK;
      thi = addr_r | PAGE_MSK;
    end else if (opc_r == OP_SEC) begin
      tlo = addr_r & ~SEC_MSK;
      thi = addr_r | SEC_MSK;
    end else if (opc_r == OP_HALF) begin
      tlo = addr_r & ~HALF_MSK;
      thi = addr_r | HALF_MSK;
    end else if (opc_r == OP_BLOCK) begin
      tlo = addr_r & ~BLK_MSK;
      thi = addr_r | BLK_MSK;
    end else if (opc_r == OP_CHIP) begin
      tlo = '0;
      thi = ARRAY_TOP;
    end
    // any overlap refuses the whole command
    hit = is_array && !pnone && !((thi < plo) || (tlo > phi)); // [RL17] [RL19]
  end

  // a modifying selection that passes every check starts a cycle
  assign go = cs_rise && seen_r && is_mod && (pwr_r == PW_NORMAL)
           && (bits_r == 3'h0)                             // [RL5]
           && wel_r                                        // [RL6]
           && !wip_r                                       // [RL18]
           && !hit;                                        // [RL17]

  // next state of the guard
  always_comb begin
    pwr_nxt   = pwr_r;
    puw_nxt   = puw_r;
    bits_nxt  = bits_r;
    seen_nxt  = seen_r;
    wip_nxt   = wip_r;
    wel_nxt   = wel_r;
    prot_nxt  = prot_r;
    rej_nxt   = rej_r;
    start_nxt = go;                                        // [RL20]
    kind_nxt  = kind_r;
    // pulse count of this selection
    if (cs_fall) begin
      bits_nxt = ck_rise ? 3'h1 : 3'h0;
      seen_nxt = ck_rise;
    end else if (!cs_q2 && ck_rise) begin
      bits_nxt = bits_r + 3'h1;                            // [RL5]
      seen_nxt = 1'b1;
    end
    // end of the running cycle
    if (wip_r && cycle_done) begin
      wip_nxt = 1'b0;                                      // [RL1] [RL20]
    end
    case (pwr_r)
      PW_INHIBIT: begin
        // nothing modifies until the timer runs out
        if (puw_r == 17'(PUW_CYCLES - 1)) pwr_nxt = PW_NORMAL; // [RL8]
        else puw_nxt = puw_r + 17'h00001;
        if (cs_rise && seen_r) rej_nxt = is_mod || (opc_r == OP_WRITE_ENABLE_CMD); // [RL8]
      end
      PW_NORMAL: begin
        if (cs_rise && seen_r) begin
          rej_nxt = 1'b0;
          if (go) begin
            wip_nxt  = 1'b1;                               // [RL1] [RL20]
            wel_nxt  = 1'b0;                               // [RL7]
            kind_nxt = opc_r;
            if ((opc_r == OP_SRW) && !hardware_protected_mode) prot_nxt = fwg_prot_s'(srd_r); // [RL10] [RL9]
          end else if (wip_r) begin
            rej_nxt = 1'b1;                                // [RL18]
          end else if (is_mod) begin
            rej_nxt = 1'b1;                                // [RL5] [RL6] [RL17]
          end else if ((opc_r == OP_WRITE_ENABLE_CMD) && (bits_r == 3'h0)) begin
            wel_nxt = 1'b1;                                // [RL6]
          end else if ((opc_r == OP_WRDIS) && (bits_r == 3'h0)) begin
            wel_nxt = 1'b0;                                // [RL7]
          end else if (opc_r == OP_SLEEP) begin
            pwr_nxt = PW_DEEP;                             // [RL3]
          end
        end
      end
      PW_DEEP: begin
        // only wake is heard here
        if (cs_rise && seen_r) begin
          if (opc_r == OP_WAKE) begin
            pwr_nxt = PW_NORMAL;                           // [RL3]
            rej_nxt = 1'b0;
          end else begin
            rej_nxt = 1'b1;                                // [RL4]
          end
        end
      end
      default: pwr_nxt = PW_INHIBIT;
    endcase
  end

  // guard registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r   <= PW_INHIBIT;                               // [RL8]
      puw_r   <= '0;
      bits_r  <= '0;
      seen_r  <= 1'b0;
      wip_r   <= 1'b0;
      wel_r   <= 1'b0;                                     // [RL7]
      prot_r  <= fwg_prot_s'(PROT_RST);
      rej_r   <= 1'b0;
      start_r <= 1'b0;
      kind_r  <= OPC_RST;
    end else begin
      pwr_r   <= pwr_nxt;
      puw_r   <= puw_nxt;
      bits_r  <= bits_nxt;
      seen_r  <= seen_nxt;
      wip_r   <= wip_nxt;
      wel_r   <= wel_nxt;
      prot_r  <= prot_nxt;
      rej_r   <= rej_nxt;
      start_r <= start_nxt;
      kind_r  <= kind_nxt;
    end
  end

  // apb slave, zero wait states, read data captured in setup
  always_comb begin
    opc_nxt  = opc_r;
    addr_nxt = addr_r;
    srd_nxt  = srd_r;
    rd_nxt   = rd_r;
    err_nxt  = err_r;
    if (psel && !penable) begin
      err_nxt = 1'b0;
      rd_nxt  = '0;
      if (paddr == OFS_CMD) begin
        rd_nxt = {24'h000000, opc_r};
      end else if (paddr == OFS_ADDR) begin
        rd_nxt = {8'h00, addr_r};
      end else if (paddr == OFS_SRDATA) begin
        rd_nxt = {24'h000000, srd_r};
      end else if (paddr == OFS_STATUS) begin
        rd_nxt = {24'h000000, hardware_protected_mode, rej_r, (pwr_r == PW_INHIBIT), !active_mode,
                  active_mode, deep_sleep, wel_r, wip_r};   // [RL1]
      end else if (paddr == OFS_PROT) begin
        rd_nxt = {24'h000000, prot_r};
      end else begin
        err_nxt = 1'b1;
      end
    end
    // writes land at the access edge
    if (psel && penable && pwrite) begin
      if (paddr == OFS_CMD) opc_nxt = pwdata[7:0];
      else if (paddr == OFS_ADDR) addr_nxt = pwdata[23:0];
      else if (paddr == OFS_SRDATA) srd_nxt = pwdata[7:0];
    end
  end

  // apb registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opc_r  <= OPC_RST;
      addr_r <= '0;
      srd_r  <= '0;
      rd_r   <= '0;
      err_r  <= 1'b0;
    end else begin
      opc_r  <= opc_nxt;
      addr_r <= addr_nxt;
      srd_r  <= srd_nxt;
      rd_r   <= rd_nxt;
      err_r  <= err_nxt;
    end
  end

  // outputs
  assign prdata       = rd_r;
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & err_r;
  assign cycle_start  = start_r;
  assign cycle_opcode = kind_r;
  assign active_mode  = !cs_q2 || wip_r;                   // [RL2]
  assign deep_sleep   = (pwr_r == PW_DEEP);                // [RL3]

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wip_start_set: assert property (go |=> wip_r && start_r) // [RL20]
    else $error("busy flag not raised with cycle start");
  a_wip_holds_busy: assert property (wip_r && !cycle_done |=> wip_r) // [RL1]
    else $error("busy flag dropped before cycle end");
  a_deep_ignores: assert property (deep_sleep && opc_r != OP_WAKE |-> !go ##1 deep_sleep) // [RL4]
    else $error("command acted on in deep power-down");
  a_wel_needed: assert property (go |-> wel_r ##1 !wel_r) // [RL6]
    else $error("modifying command without write enable");
  a_bits_aligned: assert property (go |-> bits_r == 3'h0 && seen_r) // [RL5]
    else $error("command accepted off a byte boundary");
  a_puw_blocks: assert property (pwr_r == PW_INHIBIT |-> !go && !$rose(wel_r)) // [RL8]
    else $error("modification during power-up inhibit");
  a_hpm_locks: assert property ($changed(prot_r) |-> !$past(hardware_protected_mode)) // [RL10]
    else $error("protection bits changed while locked");
  a_prot_refuses: assert property (is_array && hit && cs_rise |=> !start_r) // [RL17]
    else $error("protected region was modified");
  a_all_protect: assert property (!prot_r.cmp && prot_r.bp[2:1] == 2'h3 && is_array |-> hit) // [RL13]
    else $error("whole array not protected");
  a_active_sel: assert property (!cs_q2 || wip_r |-> active_mode) // [RL2]
    else $error("not active while selected or busy");
  a_busy_refuse: assert property (wip_r && cs_rise |=> !start_r) // [RL18]
    else $error("new cycle started during a running one");
  c_program: cover property (go && opc_r == OP_PAGE);
  c_sleep_wake: cover property (deep_sleep ##[1:1000] !deep_sleep);
  c_prot_hit: cover property (cs_rise && hit && wel_r);
  c_status_write: cover property (go && opc_r == OP_SRW);
endmodule : fwg_guard
`default_nettype wire

// *** verification/fwg_spi_host.sv ***
// spi host model that drives chip select and serial clock
`default_nettype none
module fwg_spi_host (
  output logic cs_n, // chip select, active low
  output logic sclk  // serial clock, idle low
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // one selection of n rising edges, 80 ns period, off the pclk phase
  task automatic frame(input int n);
    #3;
    cs_n = 1'b0;
    #40;
    repeat (n) begin
      sclk = 1'b1;
      #40;
      sclk = 1'b0;
      #40;
    end
    cs_n = 1'b1;
    #160;
  endtask : frame
endmodule : fwg_spi_host
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the flash write guard
`default_nettype none
module tb
  import fwg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, wp_n, cycle_done;
  logic [7:0]  paddr, cycle_opcode;
  logic [31:0] pwdata, prdata, q, starts, s0;
  logic        pready, pslverr, perr, cs_n, sclk, cycle_start, active_mode, deep_sleep;
  int          err_total, checks_done;
  // prot byte, refused page address, accepted page address
  localparam logic [55:0] TBL [10] = '{
    {8'h01, 24'h1f0000, 24'h1eff00}, {8'h05, 24'h100000, 24'h0fff00},
    {8'h09, 24'h00ff00, 24'h010000}, {8'h0d, 24'h0fff00, 24'h100000},
    {8'h11, 24'h1ff000, 24'h1fef00}, {8'h15, 24'h1f8000, 24'h1f7f00},
    {8'h19, 24'h000f00, 24'h001000}, {8'h1c, 24'h007f00, 24'h008000},
    {8'h21, 24'h1eff00, 24'h1f0000}, {8'h39, 24'h001000, 24'h000f00}};
  localparam logic [7:0] OPS [8] = '{OP_SRW2, OP_SRW3, OP_PAGE, OP_QPAGE,
                                     OP_SEC, OP_HALF, OP_BLOCK, OP_CHIP};
  fwg_guard #(.PUW_CYCLES(200)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .wp_n(wp_n),
    .cycle_done(cycle_done), .cycle_start(cycle_start),
    .cycle_opcode(cycle_opcode), .active_mode(active_mode),
    .deep_sleep(deep_sleep));
  fwg_spi_host spi_host (.cs_n(cs_n), .sclk(sclk));
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // count accepted internal cycles
  always @(posedge pclk) begin
    if (!presetn) starts <= '0;
    else if (cycle_start === 1'b1) starts <= starts + 1;
  end
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // compare and count
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer, result in q and perr
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q    = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // load opcode and address, then one selection of n pulses
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
    apb(1'b1, OFS_CMD, {24'h0, op});
    apb(1'b1, OFS_ADDR, {8'h0, a});
    spi_host.frame(n);
  endtask : cmd
  task automatic wel_is(input logic e);
    apb(1'b0, OFS_STATUS, '0);
    chk("wel", {31'h0, q[1]}, {31'h0, e});
  endtask : wel_is
  // end the running internal cycle
  task automatic finish_cycle;
    @(posedge pclk);
    cycle_done <= 1'b1;
    @(posedge pclk);
    cycle_done <= 1'b0;
  endtask : finish_cycle
  // issue a command and judge acceptance and the busy window
  task automatic run(input logic [7:0] op, input logic [23:0] a, input int n, input logic e);
    s0 = starts;
    cmd(op, a, n);
    chk("accepted", starts - s0, {31'h0, e});
    apb(1'b0, OFS_STATUS, '0);
    if (e) begin
      chk("opcode", {24'h0, cycle_opcode}, {24'h0, op});
      chk("wip wel", {30'h0, q[1:0]}, 32'h1);
      chk("active busy", {31'h0, active_mode}, 32'h1);
      finish_cycle;
      apb(1'b0, OFS_STATUS, '0);
      chk("standby idle", {29'h0, q[4:3], q[0]}, 32'h4);
    end else begin
      chk("refused flag", {31'h0, q[6]}, 32'h1);
    end
  endtask : run
  // status write of new protection bits, e is the expected result
  task automatic set_prot(input logic [7:0] p, input logic [7:0] e);
    cmd(OP_WRITE_ENABLE_CMD, '0, 8);
    apb(1'b1, OFS_SRDATA, {24'h0, p});
    run(OP_SRW, '0, 16, 1'b1);
    apb(1'b0, OFS_PROT, '0);
    chk("prot", q, {24'h0, e});
  endtask : set_prot
  // hang guard
  initial begin
    #600000;
    err_total++;
    complete_run;
  end
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, cycle_done} = '0;
    {paddr, pwdata} = '0;
    wp_n = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_STATUS, '0);
    chk("inhibit", {31'h0, q[5]}, 32'h1);
    cmd(OP_WRITE_ENABLE_CMD, '0, 8);
    wel_is(1'b0);
    repeat (200) @(posedge pclk);
    apb(1'b0, OFS_STATUS, '0);
    chk("inhibit over", {31'h0, q[5]}, 32'h0);
    apb(1'b0, 8'h20, '0);
    chk("unmapped", {perr, q[30:0]}, 32'h80000000);
    run(OP_PAGE, '0, 40, 1'b0);
    cmd(OP_WRITE_ENABLE_CMD, '0, 7);
    wel_is(1'b0);
    cmd(OP_WRITE_ENABLE_CMD, '0, 8);
    wel_is(1'b1);
    run(OP_PAGE, '0, 39, 1'b0);
    wel_is(1'b1);
    cmd(OP_WRDIS, '0, 8);
    wel_is(1'b0);
    // selection during a running cycle is ignored
    cmd(OP_WRITE_ENABLE_CMD, '0, 8);
    cmd(OP_SEC, '0, 32);
    cmd(OP_WRITE_ENABLE_CMD, '0, 8);
    wel_is(1'b0);
    chk("active", {31'h0, active_mode}, 32'h1);
    finish_cycle;
    for (int i = 0; i < 8; i++) begin
      cmd(OP_WRITE_ENABLE_CMD, '0, 8);
      run(OPS[i], '0, 32, 1'b1);
    end
    // protected range table
    for (int i = 0; i < 10; i++) begin
      set_prot(TBL[i][55:48], TBL[i][55:48]);
      cmd(OP_WRITE_ENABLE_CMD, '0, 8);
      run(OP_PAGE, TBL[i][47:24], 40, 1'b0);
      cmd(OP_WRITE_ENABLE_CMD, '0, 8);
      run(OP_PAGE, TBL[i][23:0], 40, 1'b1);
    end
    set_prot(8'h01, 8'h01);
    cmd(OP_WRITE_ENABLE_CMD, '0, 8);
    run(OP_HALF, 24'h1f8000, 32, 1'b0);
    run(OP_CHIP, '0, 32, 1'b0);
    set_prot(8'h06, 8'h06);
    cmd(OP_WRITE_ENABLE_CMD, '0, 8);
    run(OP_PAGE, '0, 40, 1'b0);
    set_prot(8'h00, 8'h00);
    cmd(OP_WRITE_ENABLE_CMD, '0, 8);
    run(OP_PAGE, 24'h1fff00, 40, 1'b1);
    // write-protect pin locks the bits
    set_prot(8'h40, 8'h40);
    @(posedge pclk);
    wp_n <= 1'b0;
    set_prot(8'h00, 8'h40);
    apb(1'b0, OFS_STATUS, '0);
    chk("hpm", {31'h0, q[7]}, 32'h1);
    @(posedge pclk);
    wp_n <= 1'b1;
    set_prot(8'h00, 8'h00);
    // deep power-down entry and exit
    cmd(OP_SLEEP, '0, 8);
    chk("deep", {31'h0, deep_sleep}, 32'h1);
    cmd(OP_WRITE_ENABLE_CMD, '0, 8);
    wel_is(1'b0);
    cmd(OP_WAKE, '0, 32);
    chk("awake", {31'h0, deep_sleep}, 32'h0);
    cmd(OP_WRITE_ENABLE_CMD, '0, 8);
    wel_is(1'b1);
    complete_run;
  end
endmodule : tb
`default_nettype wire
